// ---- rtl/pptc_pkg.sv ----
// Package for the per-port priority and tag control register bank.
package pptc_pkg;
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;
    localparam int          NUM_PORTS         = 4;
    localparam logic [7:0]  PORT1_CTRL_OFF    = 8'h20;
    localparam logic [7:0]  PORT2_CTRL_OFF    = 8'h30;
    localparam logic [7:0]  PORT3_CTRL_OFF    = 8'h40;
    localparam logic [7:0]  PORT4_CTRL_OFF    = 8'h50;
    localparam logic [7:0]  RSVD_SLOT_16_OFF  = 8'h10;
    localparam logic [7:0]  PORT_CTRL_RST     = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED_VAL   = 8'h00;
    localparam logic [1:0]  QUEUE_RST         = 2'h0;
    localparam int          BIT_STORM         = 7;
    localparam int          BIT_DSCP          = 6;
    localparam int          BIT_UPRI          = 5;
    localparam int          BIT_PRIO_HI       = 4;
    localparam int          BIT_PRIO_LO       = 3;
    localparam int          BIT_TAG_INS       = 2;
    localparam int          BIT_TAG_REM       = 1;
    localparam int          BIT_QSPLIT        = 0;

    // Classification request for a received frame.
    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        logic       dscp_ok;
        logic [1:0] dscp_prio;
        logic       upri_ok;
        logic [1:0] upri_prio;
    } pptc_cls_req_s;

    // Egress tag request for an outgoing frame.
    typedef struct packed {
        logic       valid;
        logic [1:0] egress_port;
        logic [1:0] ingress_port;
        logic       rx_tagged;
    } pptc_tag_req_s;

    // Egress tag decision.
    typedef struct packed {
        logic       valid;
        logic       insert;
        logic       strip;
        logic [1:0] vid_port;
    } pptc_tag_rsp_s;
endpackage

// ---- rtl/pptc_port_ctrl.sv ----
// Per-port priority and tag control registers with frame decision logic.
//
// Operation
// - One control byte per port at fixed offsets.
// - Bit 7 enables ingress broadcast storm protection.
// - Bit 6 enables DiffServ priority classification.
// - Bit 5 enables 802.1p priority classification.
// - Bits 4:3 select default queue directly.
// - Default queue used when classification absent.
// - All classification enables may coexist freely.
// - Both results ORed, replacing default.
// - Bit 2 inserts tag on untagged frames.
// - Already tagged frames never get second tag.
// - Inserted tag uses ingress port VID.
// - Bit 1 strips tag from tagged frames.
// - Untagged frames pass unmodified under removal.
// - Bits 7:1 reset to zero.
// - Bit 0 is read/write queue split enable.
`timescale 1ns/10ps

module pptc_port_ctrl
    import pptc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic [pptc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [pptc_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [pptc_pkg::DATA_W-1:0]   reg_rdata,
    input  wire pptc_pkg::pptc_cls_req_s       cls_req,
    output logic                               cls_valid,
    output logic      [1:0]                    cls_queue,
    output logic                               cls_storm_en,
    input  wire pptc_pkg::pptc_tag_req_s       tag_req,
    output pptc_pkg::pptc_tag_rsp_s            tag_rsp,
    output logic      [3:0]                    qsplit_en
);
    import pptc_pkg::*;

    logic [DATA_W-1:0] ctrl_ff [NUM_PORTS];
    logic [DATA_W-1:0] rdata_ff;
    logic              cls_valid_ff;
    logic [1:0]        cls_queue_ff;
    logic              cls_storm_ff;
    pptc_tag_rsp_s     tag_rsp_ff;
    logic [3:0]        qsplit_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [1:0]        nxt_queue;
    logic [DATA_W-1:0] icfg;
    logic [DATA_W-1:0] ecfg;
    logic              wr_hit;
    logic [1:0]        wr_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    always_comb begin
        wr_hit = 1'b1;
        wr_idx = 2'd0;
        if (reg_addr == PORT1_CTRL_OFF) begin
            wr_idx = 2'd0;
        end else if (reg_addr == PORT2_CTRL_OFF) begin
            wr_idx = 2'd1;
        end else if (reg_addr == PORT3_CTRL_OFF) begin
            wr_idx = 2'd2;
        end else if (reg_addr == PORT4_CTRL_OFF) begin
            wr_idx = 2'd3;
        end else begin
            wr_hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                ctrl_ff[i] <= PORT_CTRL_RST;
            end
        end else if (reg_wr && wr_hit) begin
            ctrl_ff[wr_idx] <= reg_wdata;
        end
    end

    // Read data, one cycle later; unmapped reads return zero.
    always_comb begin
        nxt_rdata = RD_UNMAPPED_VAL;
        if (reg_rd && wr_hit) begin
            nxt_rdata = ctrl_ff[wr_idx];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= RD_UNMAPPED_VAL;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qsplit_ff <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                qsplit_ff[i] <= ctrl_ff[i][BIT_QSPLIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ingress classification.

    assign icfg = ctrl_ff[cls_req.port];

    always_comb begin
        nxt_queue = icfg[BIT_PRIO_HI:BIT_PRIO_LO];
        if ((icfg[BIT_DSCP] && cls_req.dscp_ok) || (icfg[BIT_UPRI] && cls_req.upri_ok)) begin
            nxt_queue = ((icfg[BIT_DSCP] && cls_req.dscp_ok) ? cls_req.dscp_prio : 2'b00)
                      | ((icfg[BIT_UPRI] && cls_req.upri_ok) ? cls_req.upri_prio : 2'b00);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cls_valid_ff <= 1'b0;
            cls_queue_ff <= QUEUE_RST;
            cls_storm_ff <= 1'b0;
        end else begin
            cls_valid_ff <= cls_req.valid;
            cls_queue_ff <= cls_req.valid ? nxt_queue : QUEUE_RST;
            cls_storm_ff <= cls_req.valid && icfg[BIT_STORM];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Egress tag handling.

    assign ecfg = ctrl_ff[tag_req.egress_port];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tag_rsp_ff <= '0;
        end else begin
            tag_rsp_ff.valid <= tag_req.valid;
            tag_rsp_ff.insert <= tag_req.valid && ecfg[BIT_TAG_INS] && !tag_req.rx_tagged;
            tag_rsp_ff.strip <= tag_req.valid && ecfg[BIT_TAG_REM] && tag_req.rx_tagged;
            tag_rsp_ff.vid_port <= tag_req.valid ? tag_req.ingress_port : 2'd0;
        end
    end

    assign reg_rdata    = rdata_ff;
    assign cls_valid    = cls_valid_ff;
    assign cls_queue    = cls_queue_ff;
    assign cls_storm_en = cls_storm_ff;
    assign tag_rsp      = tag_rsp_ff;
    assign qsplit_en    = qsplit_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_wr_p1;
        reg_wr && reg_addr == PORT1_CTRL_OFF;
    endsequence

    AST_P1_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr_p1 ##1 (reg_rd && reg_addr == PORT1_CTRL_OFF && !reg_wr)
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Port 1 readback mismatch.");

    AST_STORM: assert property (@(posedge clk) disable iff (!reset_n)
        cls_req.valid |=> cls_storm_en == $past(icfg[BIT_STORM]))
        else $error("Storm enable wrong.");

    AST_DEFAULT_Q: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && !icfg[BIT_DSCP] && !icfg[BIT_UPRI])
            |=> cls_queue == $past(icfg[BIT_PRIO_HI:BIT_PRIO_LO]))
        else $error("Default queue not used.");

    AST_OR_Q: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && icfg[BIT_DSCP] && icfg[BIT_UPRI] && cls_req.dscp_ok && cls_req.upri_ok)
            |=> cls_queue == ($past(cls_req.dscp_prio) | $past(cls_req.upri_prio)))
        else $error("Combined priority wrong.");

    AST_DSCP_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && icfg[BIT_DSCP] && !icfg[BIT_UPRI] && cls_req.dscp_ok)
            |=> cls_queue == $past(cls_req.dscp_prio))
        else $error("DiffServ priority wrong.");

    AST_NO_DOUBLE_TAG: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && tag_req.rx_tagged) |=> !tag_rsp.insert)
        else $error("Second tag added.");

    AST_INSERT: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && !tag_req.rx_tagged && ecfg[BIT_TAG_INS])
            |=> tag_rsp.insert && tag_rsp.vid_port == $past(tag_req.ingress_port))
        else $error("Tag not inserted.");

    AST_STRIP: assert property (@(posedge clk) disable iff (!reset_n)
        tag_req.valid |=> tag_rsp.strip == $past(ecfg[BIT_TAG_REM] && tag_req.rx_tagged))
        else $error("Tag removal wrong.");

    AST_UNTAGGED_PASS: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && !tag_req.rx_tagged) |=> !tag_rsp.strip)
        else $error("Untagged frame modified.");

    AST_RESET_ZERO: assert property (@(posedge clk)
        $rose(reset_n) |-> reg_rdata == 8'h00 && !cls_storm_en && qsplit_en == 4'h0)
        else $error("Reset value not zero.");

    ////////////////////////////////////////////////////////////////////////////
    // Further register and frame checks.

    sequence s_wr_at(logic [ADDR_W-1:0] off);
        reg_wr && reg_addr == off;
    endsequence

    sequence s_rd_at(logic [ADDR_W-1:0] off);
        reg_rd && reg_addr == off && !reg_wr;
    endsequence

    sequence s_port_write;
        reg_wr && wr_hit;
    endsequence

    sequence s_stray_write;
        reg_wr && !wr_hit;
    endsequence

    AST_P2_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr_at(PORT2_CTRL_OFF) ##1 s_rd_at(PORT2_CTRL_OFF)
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Port 2 readback mismatch.");

    AST_P3_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr_at(PORT3_CTRL_OFF) ##1 s_rd_at(PORT3_CTRL_OFF)
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Port 3 readback mismatch.");

    AST_P4_READBACK: assert property (@(posedge clk) disable iff (!reset_n)
        s_wr_at(PORT4_CTRL_OFF) ##1 s_rd_at(PORT4_CTRL_OFF)
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Port 4 readback mismatch.");

    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!reset_n)
        s_port_write |=> ctrl_ff[$past(wr_idx)] == $past(reg_wdata))
        else $error("Port write lost.");

    AST_STRAY_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        s_stray_write |=> $stable({ctrl_ff[0], ctrl_ff[1], ctrl_ff[2], ctrl_ff[3]}))
        else $error("Stray write changed a port byte.");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && !wr_hit) |=> reg_rdata == RD_UNMAPPED_VAL)
        else $error("Unmapped read not zero.");

    AST_RDATA_ONE_CYCLE: assert property (@(posedge clk) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == RD_UNMAPPED_VAL)
        else $error("Read data held too long.");

    AST_UPRI_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && !icfg[BIT_DSCP] && icfg[BIT_UPRI] && cls_req.upri_ok)
            |=> cls_queue == $past(cls_req.upri_prio))
        else $error("802.1p priority wrong.");

    AST_FIELD_QUEUE: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && !icfg[BIT_DSCP] && !icfg[BIT_UPRI]
            && icfg[BIT_PRIO_HI:BIT_PRIO_LO] == 2'b11) |=> cls_queue == 2'b11)
        else $error("Default field not mapped to queue.");

    AST_UNCLASSIFIED: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && !(icfg[BIT_DSCP] && cls_req.dscp_ok)
            && !(icfg[BIT_UPRI] && cls_req.upri_ok))
            |=> cls_queue == $past(icfg[BIT_PRIO_HI:BIT_PRIO_LO]))
        else $error("Failed classification lost default.");

    AST_ALL_ENABLED: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && icfg[BIT_STORM] && icfg[BIT_DSCP] && icfg[BIT_UPRI]
            && cls_req.dscp_ok && !cls_req.upri_ok)
            |=> cls_storm_en && cls_queue == $past(cls_req.dscp_prio))
        else $error("Enables blocked each other.");

    AST_STORM_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        (cls_req.valid && !icfg[BIT_STORM]) |=> !cls_storm_en)
        else $error("Storm protection while disabled.");

    AST_CLS_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !cls_req.valid |=> cls_queue == QUEUE_RST && !cls_storm_en)
        else $error("Idle classification output not zero.");

    AST_CLS_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> cls_valid == $past(cls_req.valid))
        else $error("Classification valid wrong.");

    AST_VID_INGRESS: assert property (@(posedge clk) disable iff (!reset_n)
        tag_req.valid |=> tag_rsp.vid_port == $past(tag_req.ingress_port))
        else $error("Tag VID port wrong.");

    AST_INSERT_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && !ecfg[BIT_TAG_INS]) |=> !tag_rsp.insert)
        else $error("Tag inserted while disabled.");

    AST_STRIP_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && !ecfg[BIT_TAG_REM]) |=> !tag_rsp.strip)
        else $error("Tag stripped while disabled.");

    AST_INSERT_EGRESS: assert property (@(posedge clk) disable iff (!reset_n)
        (tag_req.valid && !tag_req.rx_tagged)
            |=> tag_rsp.insert == $past(ecfg[BIT_TAG_INS]))
        else $error("Insertion not judged by egress port.");

    AST_TAG_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> tag_rsp.valid == $past(tag_req.valid))
        else $error("Tag response valid wrong.");

    AST_TAG_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !tag_req.valid |=> !tag_rsp.insert && !tag_rsp.strip && tag_rsp.vid_port == 2'd0)
        else $error("Idle tag response not zero.");

    AST_QSPLIT: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> qsplit_en == $past({ctrl_ff[3][BIT_QSPLIT], ctrl_ff[2][BIT_QSPLIT],
                                     ctrl_ff[1][BIT_QSPLIT], ctrl_ff[0][BIT_QSPLIT]}))
        else $error("Queue split enable wrong.");

    AST_RESET_BYTES: assert property (@(posedge clk)
        $rose(reset_n) |-> ctrl_ff[0] == PORT_CTRL_RST && ctrl_ff[1] == PORT_CTRL_RST
            && ctrl_ff[2] == PORT_CTRL_RST && ctrl_ff[3] == PORT_CTRL_RST)
        else $error("Port byte not zero after reset.");

endmodule

// ---- sim/pptc_port_ctrl_bench.sv ----
// Self-checking bench for the per-port priority and tag control registers.
`timescale 1ns/10ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module pptc_port_ctrl_bench;
    import pptc_pkg::*;

    logic                clk;
    logic                reset_n;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    pptc_cls_req_s       cls_req;
    logic                cls_valid;
    logic [1:0]          cls_queue;
    logic                cls_storm_en;
    pptc_tag_req_s       tag_req;
    pptc_tag_rsp_s       tag_rsp;
    logic [3:0]          qsplit_en;
    int                  miscompares;
    int                  num_checks;
    int                  cycles = 0;
    logic [7:0]          offs [4];

    pptc_port_ctrl uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cls_req(cls_req), .cls_valid(cls_valid), .cls_queue(cls_queue),
        .cls_storm_en(cls_storm_en), .tag_req(tag_req), .tag_rsp(tag_rsp),
        .qsplit_en(qsplit_en));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and request tasks.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1;
        `CHK("reg_rdata", d, reg_rdata)
        @(posedge clk);
        #1;
        `CHK("reg_rdata", RD_UNMAPPED_VAL, reg_rdata)
    endtask

    task automatic cls(input logic [1:0] p, input logic dok, input logic [1:0] dq,
                       input logic uok, input logic [1:0] uq, input logic [1:0] eq,
                       input logic es);
        @(posedge clk);
        cls_req <= pptc_cls_req_s'{1'b1, p, dok, dq, uok, uq};
        @(posedge clk);
        cls_req <= '0;
        #1;
        `CHK("cls_valid", 1'b1, cls_valid)
        `CHK("cls_queue", eq, cls_queue)
        `CHK("cls_storm_en", es, cls_storm_en)
    endtask

    task automatic tag(input logic [1:0] eg, input logic [1:0] ig, input logic tg,
                       input logic ei, input logic es);
        @(posedge clk);
        tag_req <= pptc_tag_req_s'{1'b1, eg, ig, tg};
        @(posedge clk);
        tag_req <= '0;
        #1;
        `CHK("tag_rsp", {1'b1, ei, es, ig}, tag_rsp)
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        offs = '{PORT1_CTRL_OFF, PORT2_CTRL_OFF, PORT3_CTRL_OFF, PORT4_CTRL_OFF};
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cls_req = '0;
        tag_req = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(offs[i], 8'h00); // reset zero
        $display("test reset done");
        for (int i = 0; i < 4; i++) wr(offs[i], 8'hA4 + 8'(i)); // distinct bytes
        for (int i = 0; i < 4; i++) rd(offs[i], 8'hA4 + 8'(i)); // per port readback
        `CHK("qsplit_en", 4'b1010, qsplit_en) // bit zero
        wr(RSVD_SLOT_16_OFF, 8'hFF); // reserved ignored
        rd(RSVD_SLOT_16_OFF, 8'h00); // reserved reads zero
        rd(8'h21, 8'h00); // unmapped reads zero
        for (int i = 0; i < 4; i++) wr_rd(offs[i], 8'h5A ^ 8'(i)); // back to back
        $display("test registers done");
        for (int q = 0; q < 4; q++) begin
            wr(offs[0], {3'b100, 2'(q), 3'b000}); // default queue
            cls(2'd0, 1'b1, 2'd3, 1'b1, 2'd3, 2'(q), 1'b1);
        end
        wr(offs[1], 8'h48); // dscp only
        cls(2'd1, 1'b1, 2'd2, 1'b1, 2'd1, 2'd2, 1'b0);
        cls(2'd1, 1'b0, 2'd2, 1'b1, 2'd1, 2'd1, 1'b0); // dscp fails
        wr(offs[2], 8'h70); // both enabled
        cls(2'd2, 1'b1, 2'd1, 1'b1, 2'd2, 2'd3, 1'b0); // ored
        wr(offs[2], 8'hF0); // all enables
        cls(2'd2, 1'b1, 2'd1, 1'b0, 2'd2, 2'd1, 1'b1); // storm with dscp
        wr(offs[3], 8'h28); // 802.1p only
        cls(2'd3, 1'b1, 2'd3, 1'b0, 2'd2, 2'd1, 1'b0);
        cls(2'd3, 1'b0, 2'd0, 1'b1, 2'd2, 2'd2, 1'b0); // upri only
        $display("test classify done");
        wr(offs[0], 8'h04); // insert on port 1
        wr(offs[1], 8'h02); // strip on port 2
        wr(offs[3], 8'h00); // port 4 plain
        tag(2'd0, 2'd3, 1'b0, 1'b1, 1'b0); // insert
        tag(2'd0, 2'd2, 1'b1, 1'b0, 1'b0); // no double
        tag(2'd1, 2'd0, 1'b1, 1'b0, 1'b1); // strip
        tag(2'd1, 2'd0, 1'b0, 1'b0, 1'b0); // untagged pass
        tag(2'd3, 2'd0, 1'b0, 1'b0, 1'b0); // egress bits
        $display("test tagging done");
        end_of_test();
    end
endmodule
